// file: design/tcrm_defines.vh
// Address map, field positions and reset values of the touch converter register bank.
`ifndef TCRM_DEFINES_VH
`define TCRM_DEFINES_VH

`define TCRM_ADDR_W          10
`define TCRM_DATA_W          16
`define TCRM_ADDR_MAX        10'h3ff

`define TCRM_SETUP_CONTROL   10'h000
`define TCRM_CAL_ENABLE      10'h001
`define TCRM_CTRL_LAST       10'h007
`define TCRM_IRQ_EN_FIRST    10'h005
`define TCRM_IRQ_STAT_FIRST  10'h008
`define TCRM_IRQ_STAT_SECOND 10'h009
`define TCRM_IRQ_STAT_THIRD  10'h00a
`define TCRM_CONV_FIRST      10'h00b
`define TCRM_CONV_LAST       10'h016
`define TCRM_PART_ID         10'h017
`define TCRM_PROXIMITY       10'h042

`define TCRM_CFG_FIRST       10'h080
`define TCRM_CFG_LAST        10'h0df
`define TCRM_CFG_PER_STAGE   8
`define TCRM_STAGES          12
`define TCRM_CFG_WORDS       96
`define TCRM_CFG_IDX_W       7

`define TCRM_RES_FIRST       10'h0e0
`define TCRM_RES_LAST        10'h28f
`define TCRM_RES_WORDS       432
`define TCRM_RES_IDX_W       9

`define TCRM_CTRL_WORDS      8
`define TCRM_CTRL_RESET      16'h0000
`define TCRM_CAL_RESET       16'h0000
`define TCRM_SWRESET_BIT     10
`define TCRM_RESERVED_READ   16'h0000

`endif

// file: design/tcrm_result_ram.v
// Per-stage result store of the third bank, written by the converter and read by the host.
`timescale 1ns/1ps
`default_nettype none
`include "tcrm_defines.vh"

module tcrm_result_ram
(
	// Clock
	input  wire                         core_clk,
	// Converter write side
	input  wire                         writeEnable,
	input  wire [`TCRM_RES_IDX_W-1:0]   writeIndex,
	input  wire [`TCRM_DATA_W-1:0]      writeData,
	// Host read side
	input  wire [`TCRM_RES_IDX_W-1:0]   readIndex,
	output wire [`TCRM_DATA_W-1:0]      readData
);

	// No reset: the contents carry no defined value until the converter has run.
	reg [`TCRM_DATA_W-1:0] mem [0:`TCRM_RES_WORDS-1];

	always @(posedge core_clk)
	begin
		if (writeEnable && writeIndex < `TCRM_RES_WORDS) // R9
			mem[writeIndex] <= writeData;
	end

	// An index past the end reads as zero rather than an unknown array slot.
	assign readData = (readIndex < `TCRM_RES_WORDS) ? mem[readIndex] : `TCRM_RESERVED_READ;

endmodule
`default_nettype wire

// file: design/tcrm_register_bank.v
// Three-bank register space of the touch converter with its auto-incrementing pointer.
`timescale 1ns/1ps
`default_nettype none
`include "tcrm_defines.vh"

// What the document asks of the host and of this block
// R1: The host loads the whole stage configuration bank from 0x080 to 0x0DF first, possibly in one burst.
// R2: The host then writes the control bank from 0x000 to 0x007, possibly in one burst.
// R3: In that control burst the host writes 0x0000 to the calibration enable at 0x001.
// R4: Suggested host values are 0x82B2, 0x3230, 0x419 and 832 for 0x000 and 0x002 to 0x004.
// R5: The host afterwards writes 0x0FFF to 0x001 alone to start calibration.
// R6: On every interrupt the host reads the status register at 0x008, 0x009 or 0x00A for its mode.
// R7: The space decodes into a control bank, a stage configuration bank and a stage result bank.
// R8: Each of the twelve stages owns eight configuration words, stage n starting at 0x080 plus 8n.
// R9: Result words are refreshed by the converter after each sequence and are readable by the host.
// R10: Configuration and result words have no reset value and are valid only after configuration.
// R11: Control bank holds setup, calibration, interrupt enable, status, conversion data and ID.
// R12: The host keeps away from the reserved holes around the proximity register.
// R13: The pointer steps by one per transferred word and stops at the top instead of wrapping.
// R14: Writes to reserved addresses are dropped and reads of them return a harmless zero.
module tcrm_register_bank
#(
	// Part identification; this value is arbitrary.
	parameter [`TCRM_DATA_W-1:0] PART_ID = 16'h5a01
)
(
	// Clock and reset
	input  wire                              core_clk,
	input  wire                              reset,
	// Host word port from the serial front end
	input  wire                              addrLoad,
	input  wire [`TCRM_ADDR_W-1:0]           addrIn,
	input  wire                              wordWrite,
	input  wire [`TCRM_DATA_W-1:0]           wordData,
	input  wire                              wordRead,
	output wire [`TCRM_DATA_W-1:0]           readData,
	output wire                              readValid,
	output wire [`TCRM_ADDR_W-1:0]           pointer,
	// Converter status inputs
	input  wire [`TCRM_DATA_W-1:0]           irqStatusFirst,
	input  wire [`TCRM_DATA_W-1:0]           irqStatusSecond,
	input  wire [`TCRM_DATA_W-1:0]           irqStatusThird,
	input  wire [`TCRM_DATA_W*12-1:0]        conversionResults,
	input  wire [`TCRM_DATA_W-1:0]           proximityFlags,
	// Converter result writes
	input  wire                              resultWrite,
	input  wire [`TCRM_RES_IDX_W-1:0]        resultIndex,
	input  wire [`TCRM_DATA_W-1:0]           resultData,
	// Converter configuration reads
	input  wire [`TCRM_CFG_IDX_W-1:0]        cfgIndex,
	output wire [`TCRM_DATA_W-1:0]           cfgData,
	// Control bank outputs
	output wire [`TCRM_DATA_W-1:0]           setupControl,
	output wire [`TCRM_DATA_W-1:0]           stageCalibrationEnable,
	output wire [`TCRM_DATA_W-1:0]           setupSecond,
	output wire [`TCRM_DATA_W-1:0]           setupThird,
	output wire [`TCRM_DATA_W-1:0]           setupFourth,
	output wire [`TCRM_DATA_W-1:0]           irqEnableFirst,
	output wire [`TCRM_DATA_W-1:0]           irqEnableSecond,
	output wire [`TCRM_DATA_W-1:0]           irqEnableThird
);

	// Address decode, used by both the write and the read path.
	function inRange;
		input [`TCRM_ADDR_W-1:0] a;
		input [`TCRM_ADDR_W-1:0] lo;
		input [`TCRM_ADDR_W-1:0] hi;
		begin
			inRange = (a >= lo) && (a <= hi);
		end
	endfunction

	// Region codes of the decoded address space.
	localparam [3:0] REGION_NONE  = 4'h0;
	localparam [3:0] REGION_CTRL  = 4'h1;
	localparam [3:0] REGION_STAT1 = 4'h2;
	localparam [3:0] REGION_STAT2 = 4'h3;
	localparam [3:0] REGION_STAT3 = 4'h4;
	localparam [3:0] REGION_CONV  = 4'h5;
	localparam [3:0] REGION_ID    = 4'h6;
	localparam [3:0] REGION_PROX  = 4'h7;
	localparam [3:0] REGION_CFG   = 4'h8;
	localparam [3:0] REGION_RES   = 4'h9;

	// Sorts an address into its bank and register kind; holes fall to the neutral region.
	function [3:0] regionOf;
		input [`TCRM_ADDR_W-1:0] a;
		begin
			if (inRange(a, `TCRM_SETUP_CONTROL, `TCRM_CTRL_LAST))
				regionOf = REGION_CTRL;
			else if (a == `TCRM_IRQ_STAT_FIRST)
				regionOf = REGION_STAT1;
			else if (a == `TCRM_IRQ_STAT_SECOND)
				regionOf = REGION_STAT2;
			else if (a == `TCRM_IRQ_STAT_THIRD)
				regionOf = REGION_STAT3;
			else if (inRange(a, `TCRM_CONV_FIRST, `TCRM_CONV_LAST))
				regionOf = REGION_CONV;
			else if (a == `TCRM_PART_ID)
				regionOf = REGION_ID;
			else if (a == `TCRM_PROXIMITY)
				regionOf = REGION_PROX;
			else if (inRange(a, `TCRM_CFG_FIRST, `TCRM_CFG_LAST))
				regionOf = REGION_CFG; // R8
			else if (inRange(a, `TCRM_RES_FIRST, `TCRM_RES_LAST))
				regionOf = REGION_RES; // R9
			else
				regionOf = REGION_NONE; // R14
		end
	endfunction

	// Word index inside the configuration bank, shared by the host write and read paths.
	function [`TCRM_CFG_IDX_W-1:0] cfgSlot;
		input [`TCRM_ADDR_W-1:0] a;
		reg   [`TCRM_ADDR_W-1:0] offset;
		begin
			offset = a - `TCRM_CFG_FIRST;
			cfgSlot = offset[`TCRM_CFG_IDX_W-1:0];
		end
	endfunction

	reg  [`TCRM_ADDR_W-1:0] ptr_q;
	reg  [`TCRM_ADDR_W-1:0] ptr_d;
	reg                     exhausted_q;
	reg                     exhausted_d;
	reg  [`TCRM_DATA_W-1:0] readData_q;
	reg  [`TCRM_DATA_W-1:0] readData_d;
	reg                     readValid_q;
	reg  [`TCRM_DATA_W-1:0] cfgData_q;
	reg  [`TCRM_DATA_W-1:0] cfgData_d;
	reg  [`TCRM_DATA_W-1:0] ctrl_q [0:`TCRM_CTRL_WORDS-1];
	reg  [`TCRM_DATA_W-1:0] cfgMem [0:`TCRM_CFG_WORDS-1];
	reg  [`TCRM_DATA_W-1:0] readMux;
	wire [`TCRM_DATA_W-1:0] resultRead;
	wire [3:0]              region;
	wire                    ctrlWrite;
	wire                    cfgWrite;
	wire [`TCRM_ADDR_W-1:0] resOffset;
	wire [`TCRM_ADDR_W-1:0] convOffset;
	wire                    wordOp;
	wire                    doWrite;
	wire                    doRead;
	wire                    softReset;
	integer                 i;

	// Loading a new address takes the whole cycle; a write beats a read in the same cycle.
	assign doWrite = wordWrite && !addrLoad;
	assign doRead = wordRead && !addrLoad && !wordWrite;
	assign wordOp = doWrite || doRead;

	assign region = regionOf(ptr_q); // R7
	assign resOffset = ptr_q - `TCRM_RES_FIRST;
	assign convOffset = ptr_q - `TCRM_CONV_FIRST;

	// Once the pointer has run past the top, further writes are thrown away.
	assign softReset = doWrite && !exhausted_q && (ptr_q == `TCRM_SETUP_CONTROL)
		&& wordData[`TCRM_SWRESET_BIT];

	// Only the control and configuration banks take host writes; the rest is read-only.
	assign ctrlWrite = doWrite && !exhausted_q && (region == REGION_CTRL); // R11
	assign cfgWrite = doWrite && !exhausted_q && (region == REGION_CFG); // R8

	// Next pointer: a load wins, a word operation steps, the top address saturates.
	always @*
	begin
		ptr_d = ptr_q;
		exhausted_d = exhausted_q;
		if (addrLoad)
		begin
			ptr_d = addrIn;
			exhausted_d = 1'b0;
		end
		else if (wordOp)
		begin
			if (ptr_q == `TCRM_ADDR_MAX)
				exhausted_d = 1'b1; // R13
			else
				ptr_d = ptr_q + 10'h001; // R13
		end
	end

	// Reset parks the pointer on the setup word, where a fresh burst usually starts.
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			ptr_q <= `TCRM_SETUP_CONTROL;
			exhausted_q <= 1'b0;
		end
		else
		begin
			ptr_q <= ptr_d;
			exhausted_q <= exhausted_d;
		end
	end

	// The software reset bit returns every control word to its default and so clears itself.
	always @(posedge core_clk)
	begin
		if (reset || softReset)
		begin
			for (i = 0; i < `TCRM_CTRL_WORDS; i = i + 1)
				ctrl_q[i] <= `TCRM_CTRL_RESET;
			ctrl_q[1] <= `TCRM_CAL_RESET;
		end
		else if (ctrlWrite)
			ctrl_q[ptr_q[2:0]] <= wordData; // R11
	end

	// Configuration words keep no reset so the converter sees exactly what the host loaded.
	always @(posedge core_clk)
	begin
		if (cfgWrite)
			cfgMem[cfgSlot(ptr_q)] <= wordData; // R8
	end

	// The converter sees the word one cycle after it names its index.
	always @*
	begin
		cfgData_d = `TCRM_RESERVED_READ;
		if (cfgIndex < `TCRM_CFG_WORDS)
			cfgData_d = cfgMem[cfgIndex]; // R10
	end

	always @(posedge core_clk)
	begin
		cfgData_q <= cfgData_d;
	end

	// The converter owns the write port; the host only ever reads the result bank.
	tcrm_result_ram u_tcrm_result_ram
	(
		.core_clk    (core_clk),
		.writeEnable (resultWrite),
		.writeIndex  (resultIndex),
		.writeData   (resultData),
		.readIndex   (resOffset[`TCRM_RES_IDX_W-1:0]),
		.readData    (resultRead)
	);

	// Holes and the space past the result bank read as the neutral word.
	always @*
	begin
		readMux = `TCRM_RESERVED_READ; // R14
		case (region) // R7
			REGION_CTRL:
				readMux = ctrl_q[ptr_q[2:0]]; // R11
			REGION_STAT1:
				readMux = irqStatusFirst; // R11
			REGION_STAT2:
				readMux = irqStatusSecond;
			REGION_STAT3:
				readMux = irqStatusThird;
			REGION_CONV:
				readMux = conversionResults[convOffset[3:0]*`TCRM_DATA_W +: `TCRM_DATA_W];
			REGION_ID:
				readMux = PART_ID;
			REGION_PROX:
				readMux = proximityFlags;
			REGION_CFG:
				readMux = cfgMem[cfgSlot(ptr_q)]; // R8
			REGION_RES:
				readMux = resultRead; // R9
			default:
				readMux = `TCRM_RESERVED_READ; // R14
		endcase
	end

	// Read data holds between reads, so the host may collect it late.
	always @*
	begin
		readData_d = readData_q;
		if (doRead)
			readData_d = readMux; // R13
	end

	// At the top address reads keep returning the neutral zero word of that hole, as the pointer holds.
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			readData_q <= `TCRM_RESERVED_READ;
			readValid_q <= 1'b0;
		end
		else
		begin
			readValid_q <= doRead;
			readData_q <= readData_d;
		end
	end

	assign readData = readData_q;
	assign readValid = readValid_q;
	assign pointer = ptr_q;
	assign cfgData = cfgData_q;

	// Control words drive the converter straight from their flip-flops.
	assign setupControl = ctrl_q[0];
	assign stageCalibrationEnable = ctrl_q[1]; // R5
	assign setupSecond = ctrl_q[2];
	assign setupThird = ctrl_q[3];
	assign setupFourth = ctrl_q[4];
	assign irqEnableFirst = ctrl_q[5];
	assign irqEnableSecond = ctrl_q[6];
	assign irqEnableThird = ctrl_q[7];

endmodule
`default_nettype wire

// file: dv/tcrm_host_model.sv
// Host processor model driving the register bank word port.
`timescale 1ns/1ps
`default_nettype none
module tcrm_host_model
(
	// Clock
	input  wire logic        core_clk,
	// Word port
	output var  logic        addrLoad,
	output var  logic [9:0]  addrIn,
	output var  logic        wordWrite,
	output var  logic [15:0] wordData,
	output var  logic        wordRead,
	input  wire logic [15:0] readData,
	input  wire logic        readValid
);
	initial
	begin
		addrLoad = 1'b0;
		addrIn = 10'h000;
		wordWrite = 1'b0;
		wordData = 16'h0000;
		wordRead = 1'b0;
	end
	// Tasks start and end on a rising edge, so bursts chain without gaps.
	task automatic seek(input logic [9:0] a);
		addrLoad <= 1'b1;
		addrIn <= a;
		@(posedge core_clk);
		addrLoad <= 1'b0;
	endtask
	task automatic put(input logic [15:0] v);
		wordWrite <= 1'b1;
		wordData <= v;
		@(posedge core_clk);
	endtask
	// Released data is inverted so a stale word is never mistaken for a fresh one.
	task automatic rest();
		wordWrite <= 1'b0;
		wordData <= ~wordData;
		@(posedge core_clk);
	endtask
	task automatic get(output logic [15:0] v);
		wordRead <= 1'b1;
		@(posedge core_clk);
		wordRead <= 1'b0;
		@(posedge core_clk);
		v = readValid ? readData : ~readData;
	endtask
endmodule
`default_nettype wire

// file: dv/tcrm_register_bank_assertions.sv
// Concurrent checks on the register bank word port.
`timescale 1ns/1ps
`default_nettype none
module tcrm_register_bank_assertions
#(
	parameter [15:0] PART_ID = 16'h5a01
)
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        reset,
	// Word port
	input wire logic        addrLoad,
	input wire logic [9:0]  addrIn,
	input wire logic        wordWrite,
	input wire logic [15:0] wordData,
	input wire logic        wordRead,
	input wire logic [15:0] readData,
	input wire logic        readValid,
	input wire logic [9:0]  pointer,
	// Control bank
	input wire logic [15:0] setupControl,
	input wire logic [15:0] stageCalibrationEnable,
	input wire logic [15:0] irqEnableThird
);
	wire logic rdOp = wordRead & ~addrLoad & ~wordWrite;
	wire logic wrOp = wordWrite & ~addrLoad;
	wire logic step = (wordWrite | wordRead) & ~addrLoad;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_rdValid; rdOp |=> readValid; endproperty
	a_rdValid: assert property (p_rdValid) else $error("read unanswered");
	property p_rdPulse; !rdOp |=> !readValid; endproperty
	a_rdPulse: assert property (p_rdPulse) else $error("stray readValid");
	property p_load; addrLoad |=> pointer == $past(addrIn); endproperty
	a_load: assert property (p_load) else $error("pointer not loaded");
	property p_step; step && pointer != 10'h3ff |=> pointer == $past(pointer) + 10'h001; endproperty
	a_step: assert property (p_step) else $error("pointer did not step");
	property p_top; step && pointer == 10'h3ff |=> $stable(pointer); endproperty
	a_top: assert property (p_top) else $error("pointer wrapped");
	property p_hole; rdOp && (pointer > 10'h017 && pointer < 10'h042 || pointer > 10'h28f)
		|=> readData == 16'h0000; endproperty
	a_hole: assert property (p_hole) else $error("hole read not zero");
	property p_id; rdOp && pointer == 10'h017 |=> readData == PART_ID; endproperty
	a_id: assert property (p_id) else $error("wrong part id");
	property p_calWr; wrOp && pointer == 10'h001 |=> stageCalibrationEnable == $past(wordData); endproperty
	a_calWr: assert property (p_calWr) else $error("cal enable not written");
	property p_calHold; !(wrOp && pointer < 10'h002) |=> $stable(stageCalibrationEnable); endproperty
	a_calHold: assert property (p_calHold) else $error("cal enable disturbed");
	property p_swReset; wrOp && pointer == 10'h000 && wordData[10]
		|=> setupControl == 16'h0000 && irqEnableThird == 16'h0000; endproperty
	a_swReset: assert property (p_swReset) else $error("soft reset missed");
endmodule
bind tcrm_register_bank tcrm_register_bank_assertions #(.PART_ID(PART_ID))
	u_tcrm_register_bank_assertions (.core_clk, .reset, .addrLoad, .addrIn, .wordWrite,
	.wordData, .wordRead, .readData, .readValid, .pointer, .setupControl,
	.stageCalibrationEnable, .irqEnableThird);
`default_nettype wire

// file: dv/tb_tcrm_register_bank.sv
// Self-checking bench for the touch converter register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_tcrm_register_bank;
	localparam [15:0] ID = 16'h5a01; // Arbitrary identification value.
	logic         core_clk = 1'b0;
	logic         reset = 1'b1;
	logic         resultWrite = 1'b0;
	logic [8:0]   resultIndex = 9'h000;
	logic [15:0]  resultData = 16'h0000;
	logic [6:0]   cfgIndex = 7'h00;
	logic [15:0]  irq [0:2] = '{16'h0011, 16'h0022, 16'h0033};
	logic [15:0]  cv [0:7] = '{16'h82b2, 16'h0000, 16'h3230, 16'h0419, 16'h0340,
		16'h0001, 16'h0002, 16'h0004};
	logic [15:0]  d;
	wire          addrLoad, wordWrite, wordRead, readValid;
	wire [9:0]    addrIn, pointer;
	wire [15:0]   wordData, readData, cfgData;
	wire [15:0]   ctl [0:7];
	wire [191:0]  conv;
	int           fails = 0;
	int           n_checks = 0;
	for (genvar k = 0; k < 12; k++) assign conv[16 * k +: 16] = 16'h2000 + 16'(k);
	always #2 core_clk = ~core_clk;
	tcrm_register_bank #(.PART_ID(ID)) u_tcrm_register_bank (.core_clk, .reset, .addrLoad,
		.addrIn, .wordWrite, .wordData, .wordRead, .readData, .readValid, .pointer,
		.irqStatusFirst(irq[0]), .irqStatusSecond(irq[1]), .irqStatusThird(irq[2]),
		.conversionResults(conv), .proximityFlags(16'h0044), .resultWrite, .resultIndex,
		.resultData, .cfgIndex, .cfgData, .setupControl(ctl[0]),
		.stageCalibrationEnable(ctl[1]), .setupSecond(ctl[2]), .setupThird(ctl[3]),
		.setupFourth(ctl[4]), .irqEnableFirst(ctl[5]), .irqEnableSecond(ctl[6]),
		.irqEnableThird(ctl[7]));
	tcrm_host_model u_tcrm_host_model (.core_clk, .addrLoad, .addrIn, .wordWrite,
		.wordData, .wordRead, .readData, .readValid);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] exp);
		u_tcrm_host_model.seek(a);
		u_tcrm_host_model.get(d);
		chk("readData", exp, d);
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] v);
		u_tcrm_host_model.seek(a);
		u_tcrm_host_model.put(v);
		u_tcrm_host_model.rest();
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk("pointer", 16'h0000, {6'h00, pointer});
		chk("calEnable", 16'h0000, ctl[1]);
		$display("reset test done");
		u_tcrm_host_model.seek(10'h080);
		for (int i = 0; i < 96; i++) u_tcrm_host_model.put(16'h1000 + 16'(i));
		u_tcrm_host_model.rest();
		chk("pointer", 16'h00e0, {6'h00, pointer});
		for (int k = 0; k < 12; k++)
		begin
			cfgIndex <= 7'(8 * k);
			repeat (2) @(posedge core_clk);
			chk("cfgData", 16'h1000 + 16'(8 * k), cfgData);
		end
		cfgIndex <= 7'h60;
		repeat (2) @(posedge core_clk);
		chk("cfgData", 16'h0000, cfgData);
		rd(10'h0d8, 16'h1058);
		$display("config test done");
		u_tcrm_host_model.seek(10'h000);
		for (int i = 0; i < 8; i++) u_tcrm_host_model.put(cv[i]);
		u_tcrm_host_model.rest();
		for (int i = 0; i < 8; i++) chk("control", cv[i], ctl[i]);
		wr(10'h001, 16'h0fff);
		chk("calEnable", 16'h0fff, ctl[1]);
		$display("control test done");
		u_tcrm_host_model.seek(10'h008);
		for (int i = 0; i < 16; i++)
		begin
			u_tcrm_host_model.get(d);
			chk("bank1", i < 3 ? irq[i] : i < 15 ? conv[16 * (i - 3) +: 16] : ID, d);
		end
		$display("status test done");
		wr(10'h300, 16'hffff);
		wr(10'h042, 16'hffff);
		rd(10'h300, 16'h0000);
		rd(10'h042, 16'h0044);
		rd(10'h001, 16'h0fff);
		rd(10'h290, 16'h0000);
		$display("reserved test done");
		resultWrite <= 1'b1;
		resultData <= 16'h7e01;
		@(posedge core_clk);
		resultIndex <= 9'd431;
		resultData <= 16'h7e02;
		@(posedge core_clk);
		resultWrite <= 1'b0;
		rd(10'h0e0, 16'h7e01);
		rd(10'h28f, 16'h7e02);
		$display("result test done");
		rd(10'h3ff, 16'h0000);
		u_tcrm_host_model.get(d);
		chk("readData", 16'h0000, d);
		chk("pointer", 16'h03ff, {6'h00, pointer});
		wr(10'h000, 16'h0400);
		for (int i = 0; i < 8; i++) chk("control", 16'h0000, ctl[i]);
		$display("pointer test done");
		conclude();
	end
	initial
	begin
		#20000;
		fails++;
		conclude();
	end
endmodule
`default_nettype wire
